// >>> shared/cac_pkg.sv
// Constants for the card attribute configuration registers.
// Assumes one 50 MHz clock shared by card logic and socket controller.
package cac_pkg;
    // Attribute bus widths
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;

    // Attribute memory offsets
    localparam logic [10:0] OFF_CONFIG_OPTION = 11'h200;
    localparam logic [10:0] OFF_CONFIG_STATUS = 11'h202;
    localparam logic [10:0] OFF_PIN_SIGNAL    = 11'h204;
    localparam logic [10:0] OFF_DRIVE_POS     = 11'h206;

    // card_config_status fields
    localparam int CS_CHANGED_BIT = 7;
    localparam int CS_SCE_BIT     = 6;
    localparam int CS_IO8_BIT     = 5;
    localparam int CS_AUDIO_BIT   = 3;
    localparam int CS_PWRDN_BIT   = 2;
    localparam int CS_INTR_BIT    = 1;
    localparam logic [7:0] CS_WRITE_MASK = 8'h6C;

    // pin_signal_status fields
    localparam int PS_RDY_CHG_BIT = 5;
    localparam int PS_WP_CHG_BIT  = 4;
    localparam int PS_RDY_BIT     = 1;
    localparam int PS_WP_BIT      = 0;
    localparam int PS_MASK_SHIFT  = 4;
    localparam logic [7:0] PS_WRITE_MASK = 8'h3F;

    // drive_position_select fields
    localparam int DP_COPY_LSB = 4;
    localparam int DP_SOCK_LSB = 0;
    localparam logic [7:0] DP_WRITE_MASK = 8'h7F;

    // Reset and unmapped-read values
    localparam logic [7:0] RST_REG_VAL  = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;
endpackage

// >>> shared/cac_attr_if.sv
// Attribute memory link between socket controller and card.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface cac_attr_if;
    // Host to card access strobes
    logic [10:0] addr;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  wdata;
    // Card answers
    logic [7:0]  rdata;
    logic        rvalid;
    // Card pins toward the socket
    logic        status_change_output_n;
    logic        host_irq_n;

    // Card end
    modport dev (
        input  addr, wr_stb, rd_stb, wdata,
        output rdata, rvalid, status_change_output_n, host_irq_n
    );
    // Socket controller end
    modport host (
        output addr, wr_stb, rd_stb, wdata,
        input  rdata, rvalid, status_change_output_n, host_irq_n
    );
endinterface
`default_nettype wire

// >>> logic/cac_card_regs.sv
// Card-side attribute configuration registers (status, pin, position).
// Assumes strobes from a socket controller on the same clock and
// card status inputs from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1 - Config/status register at 202H, six fields
// R2 - Reserved bit 4 always reads zero
// R3 - Bit 2 set requests card power-down
// R4 - ATA commands may also enter power-down
// R5 - Bit 1 reads live interrupt pin level
// R6 - Pin register at 204H, flags and states
// R7 - Low nibble masks writes to upper nibble
// R8 - Host writes zeros to pin bits 7:6
// R9 - Position register 206H: copy, socket fields
// R10 - Position register substitutes master/slave selection
// R11 - Host writes 206H before 200H
// R12 - Host writes zero to position bit 7
// R13 - State change sets flag; host write clears
// R14 - Summary flag drives status-change pin if enabled
module cac_card_regs (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    // Attribute link
    cac_attr_if.dev         attr,
    // Card status from the drive core
    input  wire logic       ready_in,
    input  wire logic       write_protect_in,
    input  wire logic       irq_level_in,
    input  wire logic       ata_power_down_in,
    // Configuration toward the drive core
    output logic            power_down_out,
    output logic            power_down_request_out,
    output logic            eight_bit_io_select_out,
    output logic            audio_enable_out,
    output logic [2:0]      copy_number_out,
    output logic [3:0]      socket_number_out
);

    // Whole module state
    typedef struct packed {
        logic       status_change_enable;
        logic       eight_bit_io_select;
        logic       audio_enable;
        logic       power_down_request;
        logic       irq_level;
        logic       ready_change_flag;
        logic       write_protect_change_flag;
        logic       ready_state;
        logic       write_protect_pin_state;
        logic       primed;
        logic [2:0] copy_number;
        logic [3:0] socket_number;
        logic [7:0] rdata;
        logic       rvalid;
        logic       status_change_output_n;
        logic       host_irq_n;
        logic       power_down;
    } cac_card_state_t;

    localparam cac_card_state_t STATE_RESET = '{
        status_change_enable      : 1'b0,
        eight_bit_io_select       : 1'b0,
        audio_enable              : 1'b0,
        power_down_request        : 1'b0,
        irq_level                 : 1'b0,
        ready_change_flag         : 1'b0,
        write_protect_change_flag : 1'b0,
        ready_state               : 1'b0,
        write_protect_pin_state   : 1'b0,
        primed                    : 1'b0,
        copy_number               : 3'h0,
        socket_number             : 4'h0,
        rdata                     : cac_pkg::RST_REG_VAL,
        rvalid                    : 1'b0,
        status_change_output_n    : 1'b1,
        host_irq_n                : 1'b1,
        power_down                : 1'b0
    };

    cac_card_state_t state_q;
    cac_card_state_t state_d;

    // Masked update of one upper bit by its lower enable bit
    function automatic logic cac_masked(input logic old_val, input logic [7:0] data,
                                        input int bit_pos);
        logic en;
        en = data[bit_pos - cac_pkg::PS_MASK_SHIFT];
        cac_masked = en ? data[bit_pos] : old_val;
    endfunction

    // Decoded strobes and change events
    logic       wr_cs;
    logic       wr_ps;
    logic       wr_dp;
    logic       rdy_event;
    logic       wp_event;
    logic       changed;
    logic [7:0] cs_word;
    logic [7:0] ps_word;
    logic [7:0] dp_word;

    // Address decode and readback words
    always_comb begin
        wr_cs     = attr.wr_stb && (attr.addr == cac_pkg::OFF_CONFIG_STATUS);
        wr_ps     = attr.wr_stb && (attr.addr == cac_pkg::OFF_PIN_SIGNAL);
        wr_dp     = attr.wr_stb && (attr.addr == cac_pkg::OFF_DRIVE_POS);
        rdy_event = state_q.primed && (ready_in != state_q.ready_state);
        wp_event  = state_q.primed && (write_protect_in != state_q.write_protect_pin_state);
        changed   = state_q.ready_change_flag || state_q.write_protect_change_flag; // R14
        // Reserved bits 4 and 0 are constant zero
        cs_word = 8'h00; // R2
        cs_word[cac_pkg::CS_CHANGED_BIT] = changed; // R1
        cs_word[cac_pkg::CS_SCE_BIT]     = state_q.status_change_enable;
        cs_word[cac_pkg::CS_IO8_BIT]     = state_q.eight_bit_io_select;
        cs_word[cac_pkg::CS_AUDIO_BIT]   = state_q.audio_enable;
        cs_word[cac_pkg::CS_PWRDN_BIT]   = state_q.power_down_request;
        cs_word[cac_pkg::CS_INTR_BIT]    = state_q.irq_level; // R5
        ps_word = 8'h00; // R6
        ps_word[cac_pkg::PS_RDY_CHG_BIT] = state_q.ready_change_flag;
        ps_word[cac_pkg::PS_WP_CHG_BIT]  = state_q.write_protect_change_flag;
        ps_word[cac_pkg::PS_RDY_BIT]     = state_q.ready_state;
        ps_word[cac_pkg::PS_WP_BIT]      = state_q.write_protect_pin_state;
        dp_word = {1'b0, state_q.copy_number, state_q.socket_number}; // R9
    end

    // Next-state logic
    always_comb begin
        state_d = state_q;

        // Track card status each cycle; first sample only primes
        state_d.primed                  = 1'b1;
        state_d.ready_state             = ready_in;
        state_d.write_protect_pin_state = write_protect_in;
        state_d.irq_level               = irq_level_in; // R5

        // Configuration and status writes; reserved bits dropped
        if (wr_cs) begin // R1
            state_d.status_change_enable = attr.wdata[cac_pkg::CS_SCE_BIT];
            state_d.eight_bit_io_select  = attr.wdata[cac_pkg::CS_IO8_BIT];
            state_d.audio_enable         = attr.wdata[cac_pkg::CS_AUDIO_BIT];
            state_d.power_down_request   = attr.wdata[cac_pkg::CS_PWRDN_BIT]; // R3
        end

        // Masked flag writes; a change in the same cycle wins
        if (wr_ps) begin // R7
            state_d.ready_change_flag = cac_masked(state_q.ready_change_flag, attr.wdata,
                                                   cac_pkg::PS_RDY_CHG_BIT);
            state_d.write_protect_change_flag =
                cac_masked(state_q.write_protect_change_flag, attr.wdata,
                           cac_pkg::PS_WP_CHG_BIT);
        end
        if (rdy_event) begin
            state_d.ready_change_flag = 1'b1; // R13
        end
        if (wp_event) begin
            state_d.write_protect_change_flag = 1'b1; // R13
        end

        // Drive position select; bit 7 is never stored
        if (wr_dp) begin // R10
            state_d.copy_number   = attr.wdata[cac_pkg::DP_COPY_LSB +: 3]; // R9
            state_d.socket_number = attr.wdata[cac_pkg::DP_SOCK_LSB +: 4];
        end

        // Read answer one cycle after the strobe
        state_d.rvalid = attr.rd_stb;
        if (attr.rd_stb) begin
            unique case (attr.addr)
                cac_pkg::OFF_CONFIG_STATUS: state_d.rdata = cs_word;
                cac_pkg::OFF_PIN_SIGNAL:    state_d.rdata = ps_word;
                cac_pkg::OFF_DRIVE_POS:     state_d.rdata = dp_word;
                default:                    state_d.rdata = cac_pkg::UNMAPPED_VAL;
            endcase
        end

        // Status change pin only when enabled
        state_d.status_change_output_n = !(changed && state_q.status_change_enable); // R14
        state_d.host_irq_n             = !irq_level_in;

        // Either source puts the drive to sleep
        state_d.power_down = state_q.power_down_request || ata_power_down_in; // R3 R4
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Link outputs
    assign attr.rdata                  = state_q.rdata;
    assign attr.rvalid                 = state_q.rvalid;
    assign attr.status_change_output_n = state_q.status_change_output_n;
    assign attr.host_irq_n             = state_q.host_irq_n;

    // Core outputs
    assign power_down_out          = state_q.power_down;
    assign power_down_request_out  = state_q.power_down_request;
    assign eight_bit_io_select_out = state_q.eight_bit_io_select;
    assign audio_enable_out        = state_q.audio_enable;
    assign copy_number_out         = state_q.copy_number;
    assign socket_number_out       = state_q.socket_number;

endmodule
`default_nettype wire

// >>> logic/cac_socket_ctrl.sv
// Socket controller end: turns user commands into attribute accesses.
// Assumes the card end on the same clock answers reads one cycle later.
`timescale 1ns/1ps
`default_nettype none
module cac_socket_ctrl #(
    parameter bit USE_DRIVE_POS = 1'b1
) (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // User command port
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [10:0] cmd_addr_in,
    input  wire logic [7:0]  cmd_wdata_in,
    output logic             cmd_ready_out,
    output logic             cmd_refused_out,
    output logic             rsp_valid_out,
    output logic [7:0]       rsp_data_out,
    // Card pin status
    output logic             status_change_out,
    output logic             card_irq_out,
    // Attribute link
    cac_attr_if.host         attr
);

    typedef enum logic [0:0] {
        CAC_IDLE = 1'b0,
        CAC_WAIT = 1'b1
    } cac_host_fsm_t;

    typedef struct packed {
        cac_host_fsm_t fsm;
        logic          pos_written;
        logic [10:0]   addr;
        logic [7:0]    wdata;
        logic          wr_stb;
        logic          rd_stb;
        logic          refused;
        logic          rsp_valid;
        logic [7:0]    rsp_data;
        logic          status_change_output;
        logic          irq;
    } cac_host_state_t;

    cac_host_state_t state_q;
    cac_host_state_t state_d;
    logic [7:0]      clean;

    // Command handling
    always_comb begin
        state_d           = state_q;
        state_d.wr_stb    = 1'b0;
        state_d.rd_stb    = 1'b0;
        state_d.refused   = 1'b0;
        state_d.rsp_valid = 1'b0;
        state_d.status_change_output    = !attr.status_change_output_n;
        state_d.irq       = !attr.host_irq_n;
        // Reserved bits forced to zero on the way out
        unique case (cmd_addr_in)
            cac_pkg::OFF_CONFIG_STATUS: clean = cmd_wdata_in & cac_pkg::CS_WRITE_MASK;
            cac_pkg::OFF_PIN_SIGNAL:    clean = cmd_wdata_in & cac_pkg::PS_WRITE_MASK; // R8
            cac_pkg::OFF_DRIVE_POS:     clean = cmd_wdata_in & cac_pkg::DP_WRITE_MASK; // R12
            default:                    clean = cmd_wdata_in;
        endcase
        unique case (state_q.fsm)
            CAC_IDLE: begin
                if (cmd_valid_in) begin
                    state_d.addr  = cmd_addr_in;
                    state_d.wdata = clean;
                    if (!cmd_write_in) begin
                        state_d.rd_stb = 1'b1;
                        state_d.fsm    = CAC_WAIT;
                    end else if (USE_DRIVE_POS && !state_q.pos_written &&
                                 cmd_addr_in == cac_pkg::OFF_CONFIG_OPTION) begin
                        state_d.refused = 1'b1; // R11
                    end else begin
                        state_d.wr_stb = 1'b1;
                        if (cmd_addr_in == cac_pkg::OFF_DRIVE_POS) begin
                            state_d.pos_written = 1'b1; // R10
                        end
                    end
                end
            end
            CAC_WAIT: begin
                if (attr.rvalid) begin
                    state_d.rsp_valid = 1'b1;
                    state_d.rsp_data  = attr.rdata;
                    state_d.fsm       = CAC_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= '{fsm: CAC_IDLE, addr: 11'h000, wdata: 8'h00,
                         rsp_data: 8'h00, default: 1'b0};
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs
    assign attr.addr         = state_q.addr;
    assign attr.wdata        = state_q.wdata;
    assign attr.wr_stb       = state_q.wr_stb;
    assign attr.rd_stb       = state_q.rd_stb;
    assign cmd_ready_out     = (state_q.fsm == CAC_IDLE) && !state_q.rd_stb;
    assign cmd_refused_out   = state_q.refused;
    assign rsp_valid_out     = state_q.rsp_valid;
    assign rsp_data_out      = state_q.rsp_data;
    assign status_change_out = state_q.status_change_output;
    assign card_irq_out      = state_q.irq;

endmodule
`default_nettype wire

// >>> verification/cac_link_properties.sv
// Checker for the attribute link between socket controller and card.
// Assumes one clock and an active-high synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cac_link_properties (
    // Clock and reset
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    // Host to card
    input wire logic [10:0] addr,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [7:0]  wdata,
    // Card to host
    input wire logic [7:0]  rdata,
    input wire logic        rvalid,
    input wire logic        status_change_output_n,
    input wire logic        host_irq_n
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // Read of one register
    sequence rd_at(logic [10:0] a);
        rd_stb && addr == a;
    endsequence
    // Write of one register
    sequence wr_at(logic [10:0] a);
        wr_stb && addr == a;
    endsequence
    // Write then read of the same register
    sequence wr_rd(logic [10:0] a);
        wr_stb && addr == a ##1 rd_stb && addr == a;
    endsequence

    a_read_answer: assert property (rd_stb |=> rvalid)
        else $error("read strobe not answered next cycle");
    a_answer_cause: assert property (rvalid |-> $past(rd_stb))
        else $error("read answer without a read strobe");
    a_status_rsvd: assert property (rd_at(cac_pkg::OFF_CONFIG_STATUS) |=> !rdata[4] && !rdata[0])
        else $error("status reserved bits not zero");
    a_pin_rsvd: assert property (rd_at(cac_pkg::OFF_PIN_SIGNAL) |=> (rdata & 8'hCC) == 8'h00)
        else $error("pin reserved bits not zero");
    a_irq_mirror: assert property (rd_at(cac_pkg::OFF_CONFIG_STATUS) |=> rdata[1] == !$past(host_irq_n))
        else $error("interrupt bit differs from pin");
    a_summary_pin: assert property (rd_at(cac_pkg::OFF_CONFIG_STATUS)
        |=> status_change_output_n == !(rdata[7] && rdata[6]))
        else $error("status change pin differs from summary");
    a_cfg_store: assert property (wr_rd(cac_pkg::OFF_CONFIG_STATUS)
        |=> (rdata & 8'h6C) == ($past(wdata, 2) & 8'h6C))
        else $error("status write not stored");
    a_pos_store: assert property (wr_rd(cac_pkg::OFF_DRIVE_POS)
        |=> rdata == ($past(wdata, 2) & 8'h7F))
        else $error("position write not stored");
    a_cfg_wr_rsvd: assert property (wr_at(cac_pkg::OFF_CONFIG_STATUS) |-> !wdata[4] && !wdata[0])
        else $error("status write carries reserved bits");
    a_pin_wr_rsvd: assert property (wr_at(cac_pkg::OFF_PIN_SIGNAL) |-> wdata[7:6] == 2'h0)
        else $error("pin write carries reserved bits");
    a_pos_wr_rsvd: assert property (wr_at(cac_pkg::OFF_DRIVE_POS) |-> !wdata[7])
        else $error("position write carries reserved bit");
    a_reset_idle: assert property ($past(rst_in) |-> status_change_output_n && host_irq_n && !rvalid)
        else $error("card pins not idle after reset");
endmodule
`default_nettype wire

// >>> verification/card_attribute_config_regs_tb.sv
// Testbench joining socket controller and card registers.
// Assumes the link interface and both design ends compile before it.
`timescale 1ns/1ps
`default_nettype none
module card_attribute_config_regs_tb;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        cmd_valid_in = 1'b0;
    logic        cmd_write_in = 1'b0;
    logic [10:0] cmd_addr_in = 11'h000;
    logic [7:0]  cmd_wdata_in = 8'h00;
    logic        ready_in = 1'b0;
    logic        write_protect_in = 1'b0;
    logic        irq_level_in = 1'b0;
    logic        ata_power_down_in = 1'b0;
    logic        cmd_ready_out, cmd_refused_out, rsp_valid_out, status_change_out;
    logic        card_irq_out, power_down_out, power_down_request_out;
    logic        eight_bit_io_select_out, audio_enable_out;
    logic [7:0]  rsp_data_out;
    logic [2:0]  copy_number_out;
    logic [3:0]  socket_number_out;
    logic        last_ref = 1'b0;
    logic [31:0] seed = 32'h00015FD0;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;

    cac_attr_if link();
    cac_card_regs cac_card_regs_i (.sys_clk_in, .rst_in, .attr(link), .ready_in,
        .write_protect_in, .irq_level_in, .ata_power_down_in, .power_down_out,
        .power_down_request_out, .eight_bit_io_select_out, .audio_enable_out,
        .copy_number_out, .socket_number_out);
    cac_socket_ctrl #(.USE_DRIVE_POS(1'b1)) cac_socket_ctrl_i (.sys_clk_in, .rst_in,
        .cmd_valid_in, .cmd_write_in, .cmd_addr_in, .cmd_wdata_in, .cmd_ready_out,
        .cmd_refused_out, .rsp_valid_out, .rsp_data_out, .status_change_out,
        .card_irq_out, .attr(link));
    cac_link_properties cac_link_properties_i (.sys_clk_in, .rst_in, .addr(link.addr),
        .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .wdata(link.wdata),
        .rdata(link.rdata), .rvalid(link.rvalid),
        .status_change_output_n(link.status_change_output_n),
        .host_irq_n(link.host_irq_n));

    // Clock and hang guard
    always #10 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            conclude();
        end
    end

    // Xorshift source
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected status and pin words
    function logic [7:0] cfg_exp(logic [7:0] d, logic irq, logic chg);
        return (d & 8'h6C) | {chg, 5'h00, irq, 1'b0};
    endfunction
    function logic [7:0] pin_exp(logic rc, logic wc, logic r, logic w);
        return {2'h0, rc, wc, 2'h0, r, w};
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Advance to just after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // One command; hold keeps valid up for a following command
    task automatic issue(input logic w, input logic [10:0] a, input logic [7:0] d, input bit hold);
        while (cmd_ready_out !== 1'b1) step(1);
        cmd_valid_in = 1'b1;
        cmd_write_in = w;
        cmd_addr_in = a;
        cmd_wdata_in = d;
        step(1);
        last_ref = cmd_refused_out;
        if (!hold) begin
            cmd_valid_in = 1'b0;
            step(1);
        end
    endtask
    task automatic rd_chk(input string name, input logic [10:0] a, input logic [7:0] exp);
        int k;
        issue(1'b0, a, 8'h00, 1'b0);
        for (k = 0; k < 6 && rsp_valid_out !== 1'b1; k++) step(1);
        check(name, rsp_data_out, exp);
    endtask

    // Main sequence
    initial begin
        logic [7:0] d;
        int         i;
        step(5);
        rst_in = 1'b0;
        rd_chk("cfg_rst", 11'h202, 8'h00);
        rd_chk("pin_rst", 11'h204, 8'h00);
        rd_chk("pos_rst", 11'h206, 8'h00);
        rd_chk("unmapped", 11'h3FE, 8'h00);
        issue(1'b1, 11'h200, 8'h00, 1'b0);
        check("early_opt", {7'h00, last_ref}, 8'h01);
        d = 8'(rnd()) | 8'h80;
        issue(1'b1, 11'h206, d, 1'b1);
        rd_chk("pos", 11'h206, d & 8'h7F);
        check("copy", {5'h00, copy_number_out}, {5'h00, d[6:4]});
        check("sock", {4'h0, socket_number_out}, {4'h0, d[3:0]});
        issue(1'b1, 11'h200, 8'h00, 1'b0);
        check("late_opt", {7'h00, last_ref}, 8'h00);
        // Status register fields, corners then random
        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'(rnd());
            issue(1'b1, 11'h202, d, 1'b1);
            rd_chk("cfg", 11'h202, cfg_exp(d, 1'b0, 1'b0));
            check("pd_req", {7'h00, power_down_request_out}, {7'h00, d[2]});
            check("pd_out", {7'h00, power_down_out}, {7'h00, d[2]});
            check("io8", {7'h00, eight_bit_io_select_out}, {7'h00, d[5]});
            check("audio", {7'h00, audio_enable_out}, {7'h00, d[3]});
        end
        issue(1'b1, 11'h202, 8'h40, 1'b0);
        ata_power_down_in = 1'b1;
        step(2);
        check("pd_ata", {7'h00, power_down_out}, 8'h01);
        ata_power_down_in = 1'b0;
        irq_level_in = 1'b1;
        step(2);
        check("pd_off", {7'h00, power_down_out}, 8'h00);
        check("irq_pin", {7'h00, card_irq_out}, 8'h01);
        rd_chk("irq", 11'h202, cfg_exp(8'h40, 1'b1, 1'b0));
        // Change flags, mask writes and summary pin
        ready_in = 1'b1;
        step(3);
        rd_chk("rdy_chg", 11'h204, pin_exp(1'b1, 1'b0, 1'b1, 1'b0));
        check("sig_on", {7'h00, status_change_out}, 8'h01);
        rd_chk("summary", 11'h202, cfg_exp(8'h40, 1'b1, 1'b1));
        issue(1'b1, 11'h204, 8'hC0, 1'b0);
        rd_chk("mask0", 11'h204, pin_exp(1'b1, 1'b0, 1'b1, 1'b0));
        write_protect_in = 1'b1;
        step(3);
        issue(1'b1, 11'h204, 8'h02, 1'b0);
        rd_chk("clr_rdy", 11'h204, pin_exp(1'b0, 1'b1, 1'b1, 1'b1));
        issue(1'b1, 11'h202, 8'h00, 1'b0);
        step(3);
        check("sig_off", {7'h00, status_change_out}, 8'h00);
        issue(1'b1, 11'h204, 8'h01, 1'b0);
        rd_chk("clr_wp", 11'h204, pin_exp(1'b0, 1'b0, 1'b1, 1'b1));
        // Mid-run reset with inputs high: priming keeps flags clear
        rst_in = 1'b1;
        step(2);
        rst_in = 1'b0;
        rd_chk("pin_rerst", 11'h204, pin_exp(1'b0, 1'b0, 1'b1, 1'b1));
        check("pos_rerst", {5'h00, copy_number_out}, 8'h00);
        issue(1'b1, 11'h200, 8'h00, 1'b0);
        check("rerst_opt", {7'h00, last_ref}, 8'h01);
        conclude();
    end
endmodule
`default_nettype wire
